//--- verilog/mgmt_irq_router.sv
// Management interrupt routing, status, soft-power Delay 2 timer and APB register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module mgmt_irq_router #(
    parameter int TICK_CYCLES = mgmt_irq_pkg::TICK_CYCLES,
    parameter int STEP_TICKS = mgmt_irq_pkg::STEP_TICKS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] first_group_irq,
    input wire logic mouse_irq,
    input wire logic kbd_irq,
    input wire logic infrared_rx,
    input wire logic kbc_port1_bit2,
    input wire logic serial_bus_irq,
    input wire logic alarm2_event,
    input wire logic delay_start,
    output logic delay_done,
    output logic mgmt_irq_n_out,
    output logic mgmt_irq_n_oe_n,
    output logic host_irq
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [13:0] sync1_q;
    logic [13:0] sync2_q;
    logic ir_prev_q;
    logic alarm_meta_q;
    logic alarm_sync_q;
    // Alarm has its own two stages below, so it is not part of this bundle
    wire [13:0] raw_in = {delay_start, serial_bus_irq, kbc_port1_bit2,
                          infrared_rx, kbd_irq, mouse_irq, first_group_irq};
    wire [7:0] first_src = sync2_q[7:0];
    wire mouse_s = sync2_q[8];
    wire kbd_s = sync2_q[9];
    wire ir_s = sync2_q[10];
    wire kbc_s = sync2_q[11];
    wire sbus_s = sync2_q[12];
    wire start_s = sync2_q[13];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            ir_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            ir_prev_q <= ir_s;
        end
    end

    // Alarm and start arrive as pulses or levels; catch rising edges after sync
    logic alarm_prev_q;
    logic start_prev_q;
    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [7:0] idx = paddr[9:2];
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire lane0 = pstrb[0];
    wire hit_en1 = idx == mgmt_irq_pkg::ENABLE_FIRST_IDX;
    wire hit_en2 = idx == mgmt_irq_pkg::ENABLE_SECOND_IDX;
    wire hit_st1 = idx == mgmt_irq_pkg::STATUS_FIRST_IDX;
    wire hit_st2 = idx == mgmt_irq_pkg::STATUS_SECOND_IDX;
    wire hit_dly = idx == mgmt_irq_pkg::DELAY_SETTING_IDX;
    wire hit_hst = idx == mgmt_irq_pkg::HOST_STATUS_IDX;
    wire hit_hmk = idx == mgmt_irq_pkg::HOST_MASK_IDX;
    wire hit_any = hit_en1 | hit_en2 | hit_st1 | hit_st2 | hit_dly | hit_hst | hit_hmk;
    wire aligned = paddr[1:0] == 2'b00 && paddr[31:10] == '0;
    wire mapped = hit_any & aligned;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] enable_first_q;
    logic [7:0] smi_enable_second_q;
    logic [7:0] soft_power_delay_setting_q;
    logic [7:0] status2_sticky_q;
    logic [mgmt_irq_pkg::HOST_WIDTH-1:0] host_status_q;
    logic [mgmt_irq_pkg::HOST_WIDTH-1:0] host_mask_q;

    wire en_wr1 = wr & mapped & lane0 & hit_en1;
    wire en_wr2 = wr & mapped & lane0 & hit_en2;
    wire dly_wr = wr & mapped & lane0 & hit_dly;
    wire st2_wr = wr & mapped & lane0 & hit_st2;
    wire st2_rd = rd & mapped & hit_st2;
    wire hst_wr = wr & mapped & lane0 & hit_hst;
    wire hmk_wr = wr & mapped & lane0 & hit_hmk;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            enable_first_q <= mgmt_irq_pkg::REG_RESET;
            smi_enable_second_q <= mgmt_irq_pkg::REG_RESET;
            soft_power_delay_setting_q <= mgmt_irq_pkg::REG_RESET;
            host_mask_q <= '0;
            alarm_prev_q <= 1'b0;
            start_prev_q <= 1'b0;
        end
        else
        begin
            if (en_wr1)
                enable_first_q <= pwdata[7:0];
            if (en_wr2)
                smi_enable_second_q <= pwdata[7:0];
            if (dly_wr)
                soft_power_delay_setting_q <= pwdata[7:0] & mgmt_irq_pkg::DELAY_FIELD_MASK;
            if (hmk_wr)
                host_mask_q <= pwdata[mgmt_irq_pkg::HOST_WIDTH-1:0];
            alarm_prev_q <= alarm_sync_q;
            start_prev_q <= start_s;
        end
    end

    // Alarm event synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            alarm_meta_q <= 1'b0;
            alarm_sync_q <= 1'b0;
        end
        else
        begin
            alarm_meta_q <= alarm2_event;
            alarm_sync_q <= alarm_meta_q;
        end
    end

    wire ir_edge = ir_s ^ ir_prev_q;
    wire alarm_rise = alarm_sync_q & ~alarm_prev_q;
    wire start_rise = start_s & ~start_prev_q;

    // ------------------------------------------------------------
    // Sticky status bits: setting wins over clearing
    // ------------------------------------------------------------
    wire [7:0] status2_set = {1'b0, alarm_rise, 2'b00, start_rise, ir_edge, 2'b00};
    wire [7:0] status2_rd_clr = st2_rd ? 8'h0C : 8'h00;
    wire [7:0] status2_wr_clr = st2_wr ? (pwdata[7:0] & mgmt_irq_pkg::STATUS2_WRITABLE) : 8'h00;
    wire [7:0] status2_clr = status2_rd_clr | status2_wr_clr;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            status2_sticky_q <= mgmt_irq_pkg::REG_RESET;
        else
            status2_sticky_q <= (status2_sticky_q & ~status2_clr) | status2_set;
    end

    wire [7:0] smi_status_first = first_src;
    wire [7:0] status2_level = {2'b00, sbus_s, kbc_s, 2'b00, kbd_s, mouse_s}
                               & mgmt_irq_pkg::STATUS2_LEVEL_MASK;
    wire [7:0] smi_status_second = status2_level | status2_sticky_q;

    // ------------------------------------------------------------
    // Group interrupt and pin
    // ------------------------------------------------------------
    wire [7:0] en2_gate = {1'b0, smi_enable_second_q[6:0]};
    wire first_hit = |(smi_status_first & enable_first_q);
    wire second_hit = |(smi_status_second & en2_gate);
    wire group_irq = first_hit | second_hit;
    wire pin_drive = smi_enable_second_q[mgmt_irq_pkg::PIN_DRIVE_BIT];

    // ------------------------------------------------------------
    // Delay 2 timer
    // ------------------------------------------------------------
    // Timer starts late by at most a few cycles and runs one extra 500 ms step, setting plus one steps in all
    logic [31:0] cyc_q;
    localparam int DELAY_STEPS_W = mgmt_irq_pkg::DELAY_WIDTH + 1;
    logic [31:0] tick_q;
    logic [DELAY_STEPS_W-1:0] step_q;
    logic busy_q;
    wire [DELAY_STEPS_W-1:0] target =
        {1'b0, soft_power_delay_setting_q[mgmt_irq_pkg::DELAY_WIDTH-1:0]}
        + DELAY_STEPS_W'(1);
    wire tick = cyc_q == 32'(TICK_CYCLES - 1);
    wire step_end = tick && tick_q == 32'(STEP_TICKS - 1);
    wire last_step = step_q == target - DELAY_STEPS_W'(1);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || start_rise)
        begin
            cyc_q <= '0;
            tick_q <= '0;
            step_q <= '0;
            busy_q <= start_rise;
        end
        else if (busy_q)
        begin
            cyc_q <= tick ? 32'd0 : cyc_q + 32'd1;
            if (tick)
                tick_q <= step_end ? 32'd0 : tick_q + 32'd1;
            if (step_end)
                step_q <= step_q + DELAY_STEPS_W'(1);
            if (step_end && last_step)
                busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    wire [mgmt_irq_pkg::HOST_WIDTH-1:0] host_set = {start_rise, ir_edge, alarm_rise, group_irq};
    wire [mgmt_irq_pkg::HOST_WIDTH-1:0] host_clr =
        hst_wr ? pwdata[mgmt_irq_pkg::HOST_WIDTH-1:0] : '0;
    wire [7:0] host_rd = {{(8-mgmt_irq_pkg::HOST_WIDTH){1'b0}}, host_status_q};
    wire [7:0] host_mk = {{(8-mgmt_irq_pkg::HOST_WIDTH){1'b0}}, host_mask_q};
    wire [7:0] rd_byte = hit_en1 ? enable_first_q :
                         hit_en2 ? smi_enable_second_q :
                         hit_st1 ? smi_status_first :
                         hit_st2 ? smi_status_second :
                         hit_dly ? soft_power_delay_setting_q :
                         hit_hst ? host_rd : host_mk;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            host_status_q <= '0;
            host_irq <= 1'b0;
            mgmt_irq_n_out <= 1'b1;
            mgmt_irq_n_oe_n <= 1'b1;
            delay_done <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            host_status_q <= (host_status_q & ~host_clr) | host_set;
            host_irq <= |(host_status_q & host_mask_q);
            mgmt_irq_n_out <= ~group_irq;
            mgmt_irq_n_oe_n <= ~pin_drive;
            delay_done <= busy_q & step_end & last_step;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= (psel & ~penable & ~pwrite & mapped) ? {24'h0, rd_byte} : 32'h0;
        end
    end
endmodule

//--- verilog/mgmt_irq_pkg.sv
// Register map, field positions and timing constants of the management interrupt router
package mgmt_irq_pkg;
    localparam logic [7:0] ENABLE_FIRST_IDX = 8'hB4;
    localparam logic [7:0] ENABLE_SECOND_IDX = 8'hB5;
    localparam logic [7:0] STATUS_FIRST_IDX = 8'hB6;
    localparam logic [7:0] STATUS_SECOND_IDX = 8'hB7;
    localparam logic [7:0] DELAY_SETTING_IDX = 8'hB8;
    localparam logic [7:0] HOST_STATUS_IDX = 8'hB9;
    localparam logic [7:0] HOST_MASK_IDX = 8'hBA;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Second enable register fields
    localparam int KBC_ROUTE_BIT = 4;
    localparam int SERIAL_BUS_BIT = 5;
    localparam int ALARM2_EN_BIT = 6;
    localparam int PIN_DRIVE_BIT = 7;
    // Second status register fields
    localparam int INFRARED_BIT = 2;
    localparam int BUTTON_BIT = 3;
    localparam int ALARM2_BIT = 6;
    localparam logic [7:0] STATUS2_LEVEL_MASK = 8'h33;
    localparam logic [7:0] STATUS2_WRITABLE = 8'h40;
    localparam logic [7:0] DELAY_FIELD_MASK = 8'h3F;
    localparam int DELAY_WIDTH = 6;
    // Host interrupt status fields
    localparam int HOST_GROUP_BIT = 0;
    localparam int HOST_ALARM2_BIT = 1;
    localparam int HOST_INFRARED_BIT = 2;
    localparam int HOST_BUTTON_BIT = 3;
    localparam int HOST_WIDTH = 4;
    // Delay timing: one step is 500 ms, measured in 1 ms ticks
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int STEP_MS = 500;
    localparam int STEP_TICKS = STEP_MS / TICK_MS;
endpackage

//--- sim/mgmt_irq_router_chk.sv
// Port-level checker for the management interrupt router
`timescale 1ns/100ps
module mgmt_irq_router_chk #(
    parameter int TICK_CYCLES = 4,
    parameter int STEP_TICKS = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic delay_start,
    input wire logic delay_done,
    input wire logic mgmt_irq_n_out,
    input wire logic mgmt_irq_n_oe_n,
    input wire logic host_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer after setup");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_ebz; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_ebz: assert property (p_ebz) else $error("refused read not zero");
    property p_byte; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("upper read bits set");
    property p_rst; $past(sys_rst) |-> mgmt_irq_n_out && mgmt_irq_n_oe_n && !host_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_dpl; delay_done |=> !delay_done; endproperty
    a_dpl: assert property (p_dpl) else $error("done not a pulse");
    property p_dmin; $rose(delay_start) |=> !delay_done [*8]; endproperty
    a_dmin: assert property (p_dmin) else $error("delay ended early");
    c_done: cover property (delay_done);
    c_ref: cover property (pready && pslverr);
    c_pin: cover property (!mgmt_irq_n_oe_n && !mgmt_irq_n_out);
endmodule
bind mgmt_irq_router mgmt_irq_router_chk #(.TICK_CYCLES(TICK_CYCLES), .STEP_TICKS(STEP_TICKS))
    u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .delay_start(delay_start), .delay_done(delay_done), .mgmt_irq_n_out(mgmt_irq_n_out),
    .mgmt_irq_n_oe_n(mgmt_irq_n_oe_n), .host_irq(host_irq));

//--- sim/host_pin_model.sv
// Host side of the shared interrupt pin, with the board pull-up
`timescale 1ns/100ps
module host_pin_model (
    input wire logic drv_n,
    input wire logic oe_n,
    output logic pin_lvl
);
    // A floating pin reads high through the pull-up
    assign pin_lvl = oe_n ? 1'b1 : drv_n;
endmodule

//--- sim/mgmt_irq_router_tb.sv
// Self-checking bench for the management interrupt router
`timescale 1ns/100ps
module mgmt_irq_router_tb;
    logic ref_clk = 0;
    logic sys_rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic pready, pslverr, delay_done, irq_n, oe_n, host_irq, pin;
    logic [7:0] grp = 0;
    logic [7:0] v;
    logic mouse = 0, kbd = 0, ir = 0, kbc = 0, sbus = 0, alarm = 0, dstart = 0;
    logic [31:0] exp_q[$];
    int err_total = 0, compares = 0, cyc = 0, n;
    always #2.5 ref_clk = ~ref_clk;
    mgmt_irq_router #(.TICK_CYCLES(4), .STEP_TICKS(3)) u_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_group_irq(grp), .mouse_irq(mouse), .kbd_irq(kbd), .infrared_rx(ir),
        .kbc_port1_bit2(kbc), .serial_bus_irq(sbus), .alarm2_event(alarm),
        .delay_start(dstart), .delay_done(delay_done), .mgmt_irq_n_out(irq_n),
        .mgmt_irq_n_oe_n(oe_n), .host_irq(host_irq));
    host_pin_model u_host (.drv_n(irq_n), .oe_n(oe_n), .pin_lvl(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        apb(1'b0, idx, 32'h0);
    endtask
    task automatic tmr(input logic [7:0] c);
        wr(8'hB8, c);
        dstart <= 1;
        n = 0;
        while (delay_done !== 1'b1 && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
        end
        dstart <= 0;
        // Sync latency on the start input is allowed for in the upper bound
        chk(32'(n >= (c + 1) * 12 && n <= (c + 1) * 12 + 44), 32'h1);
        rd(8'hB7, 8'h08);
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (pready === 1'b1 && psel && penable && !pwrite)
            chk(prdata, exp_q.size() ? exp_q.pop_front() : 32'hDEAD);
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict;
        end
    end
    initial
    begin
        void'($urandom(32'h60FF));
        repeat (20) @(posedge ref_clk);
        sys_rst <= 0;
        for (int i = 0; i < 7; i++)
            rd(8'hB4 + 8'(i), 8'h00);
        rd(8'h10, 8'h00);
        v = $urandom;
        wr(8'hB4, v);
        rd(8'hB4, v);
        v = $urandom;
        wr(8'hB8, v);
        rd(8'hB8, v & 8'h3F);
        v = $urandom;
        grp <= v;
        repeat (4) @(posedge ref_clk);
        rd(8'hB6, v);
        grp <= 0;
        {mouse, kbd, kbc, sbus} <= 4'hF;
        repeat (4) @(posedge ref_clk);
        rd(8'hB6, 8'h00);
        rd(8'hB7, 8'h33);
        {kbd, kbc, sbus} <= 3'h0;
        ir <= 1;
        repeat (4) @(posedge ref_clk);
        rd(8'hB7, 8'h05);
        rd(8'hB7, 8'h01);
        wr(8'hB5, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h1);
        wr(8'hB5, 8'h81);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h0);
        wr(8'hB5, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h1);
        mouse <= 0;
        wr(8'hB5, 8'hC0);
        alarm <= 1;
        // Two sync stages, edge, sticky bit and output register
        repeat (6) @(posedge ref_clk);
        chk(32'(pin), 32'h0);
        wr(8'hB7, 8'h00);
        rd(8'hB7, 8'h40);
        wr(8'hB7, 8'h40);
        rd(8'hB7, 8'h00);
        wr(8'hBA, 8'h0F);
        repeat (3) @(posedge ref_clk);
        chk(32'(host_irq), 32'h1);
        wr(8'hBA, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(32'(host_irq), 32'h0);
        tmr(8'h01);
        tmr(8'h3F);
        kbc <= 1;
        wr(8'hB5, 8'h80);
        repeat (6) @(posedge ref_clk);
        chk(32'(pin), 32'h1);
        wr(8'hB5, 8'h90);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h0);
        kbc <= 0;
        sbus <= 1;
        wr(8'hB5, 8'h90);
        repeat (6) @(posedge ref_clk);
        chk(32'(pin), 32'h1);
        wr(8'hB5, 8'hA0);
        repeat (3) @(posedge ref_clk);
        chk(32'(pin), 32'h0);
        sbus <= 0;
        repeat (4) @(posedge ref_clk);
        give_verdict;
    end
endmodule
